// [rtl/csf_status_flags.sv]
// status flag update logic with register port and event interrupt
//
// What this block does
// - borrow subtract: cond zero ANDs old and zero
// - other instructions leave cond zero unchanged
// - timeout flag: cleared by reset/clear/halt, set on timeout
// - powerdown flag: cleared by reset/clear, set by halt
// - overflow flag: carry into top xor out
// - zero flag follows result equals zero
// - plain subtract: cond zero equals zero flag
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module csf_status_flags
    import csf_pkg::*;
(
    input  wire logic          sys_clk_in,
    input  wire logic          resetn_in,
    input  wire csf_instr_type instr_in,
    input  wire logic          wdog_timeout_in,
    input  wire csf_bus_type   bus_in,
    output logic [7:0]         rd_data_out,
    output logic [7:0]         flags_out,
    output logic [7:0]         result_out,
    output logic               irq_out
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] result;
        logic [7:0] rdata;
    } csf_state_type;

    csf_state_type        st;
    csf_state_type        next_st;
    csf_alu_type          alu;
    logic [CSF_EVW-1:0]   events;
    logic [CSF_EVW-1:0]   evt_status;
    logic [CSF_EVW-1:0]   evt_mask;
    logic                 exec;
    logic                 wr_flags;
    logic                 wr_evt;
    logic                 wr_mask;

    csf_alu_flags u_alu (
        .instr_in (instr_in),
        .alu_out  (alu)
    );

    ////////////////////////////////////////////////////////////////////////////

    assign exec     = instr_in.valid;
    assign wr_flags = bus_in.wr && (bus_in.addr == CSF_ADDR_FLAGS);
    assign wr_evt   = bus_in.wr && (bus_in.addr == CSF_ADDR_EVT);
    assign wr_mask  = bus_in.wr && (bus_in.addr == CSF_ADDR_MASK);

    always_comb begin
        events                 = '0;
        events[CSF_EV_TIMEOUT] = wdog_timeout_in;
        events[CSF_EV_HALT]    = exec && (instr_in.op == CSF_OP_HALT);
        events[CSF_EV_OVF]     = exec && alu.arith && alu.ovf;
        events[CSF_EV_ZERO]    = exec && (alu.arith || alu.logic_op) && alu.zero;
    end

    csf_evt_regs u_evt (
        .sys_clk_in   (sys_clk_in),
        .resetn_in    (resetn_in),
        .event_in     (events),
        .wr_status_in (wr_evt),
        .wr_mask_in   (wr_mask),
        .wdata_in     (bus_in.wdata[CSF_EVW-1:0]),
        .status_out   (evt_status),
        .mask_out     (evt_mask),
        .irq_out      (irq_out)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_st = st;
        // software may preset the arithmetic flags; timeout and
        // powerdown stay read-only so a restart cause cannot be faked
        if (wr_flags) begin
            next_st.flags = (st.flags & ~CSF_FLAGS_WMASK)
                          | (bus_in.wdata & CSF_FLAGS_WMASK);
        end
        // an executing instruction overrides a same-cycle software write
        if (exec && (alu.arith || alu.logic_op)) begin
            next_st.result               = alu.res;
            next_st.flags[CSF_BIT_Z]     = alu.zero;
        end
        if (exec && alu.arith) begin
            next_st.flags[CSF_BIT_OV]    = alu.ovf;
            next_st.flags[CSF_BIT_AC]    = alu.aux;
        end
        if (exec && alu.is_sub) begin
            next_st.flags[CSF_BIT_CZ]    = alu.zero;
        end
        if (exec && alu.is_sbc) begin
            next_st.flags[CSF_BIT_CZ]    = st.flags[CSF_BIT_CZ] && alu.zero;
        end
        // cond zero otherwise held by the default copy
        if (exec && (instr_in.op == CSF_OP_CLRWDT)) begin
            next_st.flags[CSF_BIT_TO]    = 1'b0;
            next_st.flags[CSF_BIT_PDF]   = 1'b0;
        end
        if (exec && (instr_in.op == CSF_OP_HALT)) begin
            next_st.flags[CSF_BIT_TO]    = 1'b0;
            next_st.flags[CSF_BIT_PDF]   = 1'b1;
        end
        // a timeout in the clearing cycle must not be lost
        if (wdog_timeout_in) begin
            next_st.flags[CSF_BIT_TO]    = 1'b1;
        end

        next_st.rdata = 8'h00;
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                CSF_ADDR_FLAGS:  next_st.rdata = st.flags;
                CSF_ADDR_EVT:    next_st.rdata = {4'h0, evt_status};
                CSF_ADDR_MASK:   next_st.rdata = {4'h0, evt_mask};
                CSF_ADDR_RESULT: next_st.rdata = st.result;
                default:         next_st.rdata = 8'h00;
            endcase
        end
    end

    // power-up clears every flag, timeout and powerdown included
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st.flags  <= CSF_FLAGS_RST;
            st.result <= CSF_RESULT_RST;
            st.rdata  <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    assign flags_out   = st.flags;
    assign result_out  = st.result;
    assign rd_data_out = st.rdata;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    logic is_sbc_x;
    logic is_sub_x;
    logic keeps_cz;
    logic arith_x;
    logic zfam_x;
    logic clrwdt_x;
    logic halt_x;
    logic opb_inv_x;
    logic ov_ref_x;
    logic aux_ref_x;

    // independent references: sign rule for overflow, carry into bit 4 for aux
    assign opb_inv_x = alu.is_sub || alu.is_sbc;
    assign ov_ref_x  = (instr_in.a[7] == (instr_in.b[7] ^ opb_inv_x))
                    && (alu.res[7] != instr_in.a[7]);
    assign aux_ref_x = instr_in.a[4] ^ instr_in.b[4] ^ opb_inv_x ^ alu.res[4];

    assign is_sbc_x = exec && alu.is_sbc;
    assign is_sub_x = exec && alu.is_sub;
    assign keeps_cz = !(exec && (alu.is_sub || alu.is_sbc)) && !wr_flags;
    assign arith_x  = exec && alu.arith;
    assign zfam_x   = exec && (alu.arith || alu.logic_op);
    assign clrwdt_x = exec && (instr_in.op == CSF_OP_CLRWDT);
    assign halt_x   = exec && (instr_in.op == CSF_OP_HALT);

    a_sbc_cond_zero: assert property (
        is_sbc_x |=> flags_out[CSF_BIT_CZ]
            == ($past(flags_out[CSF_BIT_CZ]) && $past(alu.zero)))
        else $error("cond zero wrong after borrow subtract");

    a_other_cz_hold: assert property (
        keeps_cz |=> $stable(flags_out[CSF_BIT_CZ]))
        else $error("cond zero changed by unrelated instruction");

    a_timeout_set: assert property (
        wdog_timeout_in |=> flags_out[CSF_BIT_TO] && evt_status[CSF_EV_TIMEOUT])
        else $error("timeout flag not set");

    a_timeout_clear: assert property (
        (clrwdt_x || halt_x) && !wdog_timeout_in |=> !flags_out[CSF_BIT_TO])
        else $error("timeout flag not cleared");

    a_pdf_halt: assert property (
        halt_x |=> flags_out[CSF_BIT_PDF] && !flags_out[CSF_BIT_TO]
                   || $past(wdog_timeout_in) && flags_out[CSF_BIT_PDF])
        else $error("powerdown flag not set by halt");

    a_pdf_clear: assert property (
        clrwdt_x |=> !flags_out[CSF_BIT_PDF])
        else $error("powerdown flag not cleared");

    a_overflow_flag: assert property (
        arith_x |=> flags_out[CSF_BIT_OV] == $past(ov_ref_x))
        else $error("overflow flag mismatch");

    a_zero_flag: assert property (
        zfam_x |=> flags_out[CSF_BIT_Z] == (result_out == 8'h00))
        else $error("zero flag disagrees with result");

    a_sub_cz_eq_z: assert property (
        is_sub_x |=> flags_out[CSF_BIT_CZ] == flags_out[CSF_BIT_Z])
        else $error("cond zero differs from zero after subtract");

    a_aux_carry: assert property (
        arith_x |=> flags_out[CSF_BIT_AC] == $past(aux_ref_x))
        else $error("aux carry mismatch");

    a_irq_level: assert property (
        irq_out == |(evt_status & evt_mask))
        else $error("interrupt level disagrees with status and mask");

    a_read_once: assert property (
        bus_in.rd && bus_in.addr == CSF_ADDR_FLAGS
            |=> rd_data_out == $past(flags_out) ##1 (rd_data_out == 8'h00 || $past(bus_in.rd)))
        else $error("read data not presented for one cycle");

    c_sbc_chain: cover property (is_sub_x ##1 is_sbc_x ##1 flags_out[CSF_BIT_CZ]);
    c_halt_then_clr: cover property (halt_x ##[1:20] clrwdt_x);
    c_timeout_race: cover property (clrwdt_x && wdog_timeout_in);
    c_irq_raised: cover property ($rose(irq_out));

endmodule
`default_nettype wire

// [rtl/csf_pkg.sv]
// shared constants and carrier types of the status flag block
`default_nettype none
package csf_pkg;

    localparam int          CSF_DW          = 8;
    localparam int          CSF_EVW         = 4;

    // register addresses on the plain register port
    localparam logic [7:0]  CSF_ADDR_FLAGS  = 8'h00;
    localparam logic [7:0]  CSF_ADDR_EVT    = 8'h01;
    localparam logic [7:0]  CSF_ADDR_MASK   = 8'h02;
    localparam logic [7:0]  CSF_ADDR_RESULT = 8'h03;

    // arith_status_flags bit positions
    localparam int          CSF_BIT_CZ      = 6;
    localparam int          CSF_BIT_TO      = 5;
    localparam int          CSF_BIT_PDF     = 4;
    localparam int          CSF_BIT_OV      = 3;
    localparam int          CSF_BIT_Z       = 2;
    localparam int          CSF_BIT_AC      = 1;

    localparam logic [7:0]  CSF_FLAGS_RST   = 8'h00;
    localparam logic [7:0]  CSF_FLAGS_WMASK = 8'h4e;
    localparam logic [7:0]  CSF_RESULT_RST  = 8'h00;

    // event status and mask bit positions
    localparam int          CSF_EV_TIMEOUT  = 0;
    localparam int          CSF_EV_HALT     = 1;
    localparam int          CSF_EV_OVF      = 2;
    localparam int          CSF_EV_ZERO     = 3;
    localparam logic [3:0]  CSF_EVT_RST     = 4'h0;
    localparam logic [3:0]  CSF_MASK_RST    = 4'h0;

    typedef enum logic [3:0] {
        CSF_OP_NOP, CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC,
        CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR, CSF_OP_MOV,
        CSF_OP_CLRWDT, CSF_OP_HALT
    } csf_op_type;

    typedef struct packed {
        logic              valid;
        csf_op_type        op;
        logic [7:0]        a;
        logic [7:0]        b;
        logic              cin;
    } csf_instr_type;

    typedef struct packed {
        logic [7:0]        res;
        logic              zero;
        logic              ovf;
        logic              aux;
        logic              arith;
        logic              logic_op;
        logic              is_sub;
        logic              is_sbc;
    } csf_alu_type;

    typedef struct packed {
        logic [7:0]        addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } csf_bus_type;

endpackage
`default_nettype wire

// [rtl/csf_alu_flags.sv]
// combinational result and flag conditions of one instruction
`timescale 1ns/10ps
`default_nettype none
module csf_alu_flags
    import csf_pkg::*;
(
    input  wire csf_instr_type instr_in,
    output csf_alu_type        alu_out
);

    logic [7:0] opb;
    logic       cin;
    logic [7:0] low7;
    logic [8:0] full;
    logic [4:0] nib;

    always_comb begin
        opb = instr_in.b;
        cin = 1'b0;
        unique case (instr_in.op)
            CSF_OP_ADC: cin = instr_in.cin;
            CSF_OP_SUB: begin
                opb = ~instr_in.b;
                cin = 1'b1;
            end
            CSF_OP_SBC: begin
                opb = ~instr_in.b;
                cin = instr_in.cin;
            end
            default: cin = 1'b0;
        endcase
        low7 = {1'b0, instr_in.a[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
        full = {1'b0, instr_in.a} + {1'b0, opb} + {8'h00, cin};
        nib  = {1'b0, instr_in.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};

        alu_out          = '0;
        alu_out.is_sub   = (instr_in.op == CSF_OP_SUB);
        alu_out.is_sbc   = (instr_in.op == CSF_OP_SBC);
        alu_out.arith    = (instr_in.op == CSF_OP_ADD) || (instr_in.op == CSF_OP_ADC)
                        || alu_out.is_sub || alu_out.is_sbc;
        alu_out.logic_op = (instr_in.op == CSF_OP_AND) || (instr_in.op == CSF_OP_OR)
                        || (instr_in.op == CSF_OP_XOR) || (instr_in.op == CSF_OP_MOV);
        unique case (instr_in.op)
            CSF_OP_AND: alu_out.res = instr_in.a & instr_in.b;
            CSF_OP_OR:  alu_out.res = instr_in.a | instr_in.b;
            CSF_OP_XOR: alu_out.res = instr_in.a ^ instr_in.b;
            CSF_OP_MOV: alu_out.res = instr_in.b;
            default:    alu_out.res = full[7:0];
        endcase
        // carry into the top bit differs from carry out of it
        alu_out.ovf  = low7[7] ^ full[8];
        alu_out.zero = (alu_out.res == 8'h00);
        alu_out.aux  = nib[4];
    end

endmodule
`default_nettype wire

// [rtl/csf_evt_regs.sv]
// sticky event status, mask and level interrupt
`timescale 1ns/10ps
`default_nettype none
module csf_evt_regs
    import csf_pkg::*;
(
    input  wire logic               sys_clk_in,
    input  wire logic               resetn_in,
    input  wire logic [CSF_EVW-1:0] event_in,
    input  wire logic               wr_status_in,
    input  wire logic               wr_mask_in,
    input  wire logic [CSF_EVW-1:0] wdata_in,
    output logic [CSF_EVW-1:0]      status_out,
    output logic [CSF_EVW-1:0]      mask_out,
    output logic                    irq_out
);

    typedef struct packed {
        logic [CSF_EVW-1:0] status;
        logic [CSF_EVW-1:0] mask;
        logic               irq;
    } csf_evt_state_type;

    csf_evt_state_type st;
    csf_evt_state_type next_st;

    always_comb begin
        next_st = st;
        // a new event beats a clear in the same cycle
        if (wr_status_in) begin
            next_st.status = st.status & ~wdata_in;
        end
        next_st.status = next_st.status | event_in;
        if (wr_mask_in) begin
            next_st.mask = wdata_in;
        end
        next_st.irq = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st.status <= CSF_EVT_RST;
            st.mask   <= CSF_MASK_RST;
            st.irq    <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign status_out = st.status;
    assign mask_out   = st.mask;
    assign irq_out    = st.irq;

endmodule
`default_nettype wire

// [tb/test_csf_status_flags.sv]
// self-checking bench of the status flag block
`timescale 1ns/10ps
`default_nettype none
module test_csf_status_flags;
    import csf_pkg::*;

    logic          sys_clk_in      = 1'b0;
    logic          resetn_in       = 1'b0;
    csf_instr_type instr_in        = '0;
    logic          wdog_timeout_in = 1'b0;
    csf_bus_type   bus_in          = '0;
    logic [7:0]    rd_data_out;
    logic [7:0]    flags_out;
    logic [7:0]    result_out;
    logic          irq_out;
    int            error_cnt       = 0;
    int            samples_checked = 0;

    always #4 sys_clk_in = ~sys_clk_in;

    csf_status_flags csf_status_flags_i (
        .sys_clk_in      (sys_clk_in),
        .resetn_in       (resetn_in),
        .instr_in        (instr_in),
        .wdog_timeout_in (wdog_timeout_in),
        .bus_in          (bus_in),
        .rd_data_out     (rd_data_out),
        .flags_out       (flags_out),
        .result_out      (result_out),
        .irq_out         (irq_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // every driver idles its port after the taking edge, so calls may chain
    task automatic bus_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk_in);
        bus_in <= '{addr, data, 1'b1, 1'b0};
        @(posedge sys_clk_in);
        bus_in <= '0;
        #1;
    endtask

    task automatic bus_rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk_in);
        bus_in <= '{addr, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk_in);
        bus_in <= '0;
        #1;
        data = rd_data_out;
    endtask

    // tout lets a time-out land in the same cycle as the instruction
    task automatic exec(input csf_op_type op, input logic [7:0] a, input logic [7:0] b,
                        input logic c, input logic tout);
        @(posedge sys_clk_in);
        instr_in        <= '{1'b1, op, a, b, c};
        wdog_timeout_in <= tout;
        @(posedge sys_clk_in);
        instr_in        <= '0;
        wdog_timeout_in <= 1'b0;
        #1;
    endtask

    task automatic wdog_pulse();
        exec(CSF_OP_NOP, 8'h00, 8'h00, 1'b0, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] d;
        check(flags_out, 8'h00);
        check(result_out, 8'h00);
        check({7'h00, irq_out}, 8'h00);
        bus_rd(CSF_ADDR_FLAGS, d);
        check(d, 8'h00);
    endtask

    // zero result: cz copies z, aux from low nibble; then borrow forms AND cz
    task automatic t_subtract();
        exec(CSF_OP_SUB, 8'h05, 8'h05, 1'b0, 1'b0);
        check(flags_out, 8'h46);
        check(result_out, 8'h00);
        exec(CSF_OP_SBC, 8'h05, 8'h04, 1'b1, 1'b0);
        check(flags_out, 8'h02);
        check(result_out, 8'h01);
        exec(CSF_OP_SBC, 8'h05, 8'h05, 1'b1, 1'b0);
        check(flags_out, 8'h06);
    endtask

    task automatic t_hold_cz();
        exec(CSF_OP_SUB, 8'h05, 8'h05, 1'b0, 1'b0);
        exec(CSF_OP_ADD, 8'h80, 8'h80, 1'b0, 1'b0);
        check(flags_out, 8'h4c);
        exec(CSF_OP_AND, 8'h0f, 8'hf0, 1'b0, 1'b0);
        check(flags_out, 8'h4c);
        exec(CSF_OP_XOR, 8'h01, 8'h00, 1'b0, 1'b0);
        check(flags_out, 8'h48);
        exec(CSF_OP_NOP, 8'h00, 8'h00, 1'b0, 1'b0);
        check(flags_out, 8'h48);
        exec(CSF_OP_OR, 8'h00, 8'h00, 1'b0, 1'b0);
        check(flags_out, 8'h4c);
        exec(CSF_OP_ADC, 8'h0f, 8'h00, 1'b1, 1'b0);
        check(flags_out, 8'h42);
        check(result_out, 8'h10);
    endtask

    // carry out without carry in, and the reverse
    task automatic t_overflow();
        exec(CSF_OP_SUB, 8'h80, 8'h01, 1'b0, 1'b0);
        check(flags_out, 8'h08);
        check(result_out, 8'h7f);
        exec(CSF_OP_ADD, 8'h7f, 8'h01, 1'b0, 1'b0);
        check(flags_out, 8'h0a);
        exec(CSF_OP_ADD, 8'h01, 8'h01, 1'b0, 1'b0);
        check(flags_out, 8'h00);
    endtask

    task automatic t_watchdog();
        wdog_pulse();
        check(flags_out, 8'h20);
        exec(CSF_OP_HALT, 8'h00, 8'h00, 1'b0, 1'b0);
        check(flags_out, 8'h10);
        wdog_pulse();
        check(flags_out, 8'h30);
        exec(CSF_OP_CLRWDT, 8'h00, 8'h00, 1'b0, 1'b0);
        check(flags_out, 8'h00);
        exec(CSF_OP_HALT, 8'h00, 8'h00, 1'b0, 1'b1);
        check(flags_out, 8'h30);
        exec(CSF_OP_CLRWDT, 8'h00, 8'h00, 1'b0, 1'b1);
        check(flags_out, 8'h20);
        // power-up clearing, taken mid-run
        @(posedge sys_clk_in);
        resetn_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        #1;
        check(flags_out, 8'h00);
    endtask

    task automatic t_regs_irq();
        logic [7:0] d;
        exec(CSF_OP_ADD, 8'h7f, 8'h01, 1'b0, 1'b0);
        bus_rd(CSF_ADDR_EVT, d);
        check(d, 8'h04);
        check({7'h00, irq_out}, 8'h00);
        bus_wr(CSF_ADDR_MASK, 8'h04);
        check({7'h00, irq_out}, 8'h01);
        bus_wr(CSF_ADDR_MASK, 8'h00);
        check({7'h00, irq_out}, 8'h00);
        bus_wr(CSF_ADDR_MASK, 8'h04);
        bus_wr(CSF_ADDR_EVT, 8'h04);
        check({7'h00, irq_out}, 8'h00);
        bus_rd(CSF_ADDR_EVT, d);
        check(d, 8'h00);
        bus_rd(CSF_ADDR_MASK, d);
        check(d, 8'h04);
        bus_rd(8'h07, d);
        check(d, 8'h00);
        bus_wr(CSF_ADDR_RESULT, 8'h55);
        bus_rd(CSF_ADDR_RESULT, d);
        check(d, 8'h80);
        // software cannot reach the time-out and power-down bits
        wdog_pulse();
        bus_wr(CSF_ADDR_FLAGS, 8'hff);
        bus_rd(CSF_ADDR_FLAGS, d);
        check(d, 8'h6e);
        bus_wr(CSF_ADDR_FLAGS, 8'h40);
        exec(CSF_OP_SBC, 8'h05, 8'h05, 1'b1, 1'b0);
        check(flags_out, 8'h66);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        #1;
        t_reset();
        t_subtract();
        t_hold_cz();
        t_overflow();
        t_watchdog();
        t_regs_irq();
        close_out();
    end

    // the whole sequence needs under a hundred cycles; this allows 5000, over fifty times that
    initial begin
        #(8 * 5000);
        error_cnt++;
        close_out();
    end

endmodule
`default_nettype wire
